// ==== design/adcsop_pkg.sv ====
/*
 * Shared constants and types of the sample output port of a 12-bit converter.
 * Assumes a 250 MHz system clock and a quantiser that delivers signed LSB counts.
 */
package adcsop_pkg;

	localparam int unsigned CODE_W           = 12;
	localparam int unsigned VIN_W            = 14;
	localparam int unsigned FIFO_DEPTH       = 16;
	localparam int unsigned CLK_FREQ_MHZ     = 250;
	localparam int unsigned CLOCK_HIGH_MAX_NS = 300;
	localparam int unsigned CLOCK_HIGH_MAX_CYC = (CLOCK_HIGH_MAX_NS * CLK_FREQ_MHZ) / 1000;
	localparam int unsigned HIGH_CNT_W       = 8;

	localparam logic signed [VIN_W:0] MID_OFFSET = 15'sh0800;
	localparam logic signed [VIN_W:0] CODE_TOP   = 15'sh0FFF;
	localparam logic signed [VIN_W-1:0] FS_TOP   = 14'sh07FF;
	localparam logic signed [VIN_W-1:0] OVR_LSB  = 14'sh0001;
	localparam logic [CODE_W-1:0] CODE_ZERO      = 12'h000;
	localparam logic [CODE_W-1:0] CODE_ONES      = 12'hFFF;
	localparam logic [VIN_W-1:0] VIN_RESET       = 14'h0000;
	localparam logic [HIGH_CNT_W-1:0] HIGH_CNT_RESET = 8'h00;

	typedef struct packed {
		logic              overrange_flag;
		logic [CODE_W-1:0] sample_code;
	} adcsop_word_t;

	localparam int unsigned WORD_W = $bits(adcsop_word_t);
	localparam adcsop_word_t WORD_RESET = '{overrange_flag: 1'b0, sample_code: 12'h000};

endpackage

// ==== design/adcsop_fifo.sv ====
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes an active-low reset that is released in step with the clock.
 */
`timescale 1ns/10ps
module adcsop_fifo #(
	parameter int unsigned WIDTH = 13,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_in_data,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	output logic [WIDTH-1:0]      o_out_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;
	logic             full;
	logic             empty;

	assign full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty       = (wr_ptr_reg == rd_ptr_reg);
	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
	assign push        = i_in_valid && !full;
	assign pop         = i_out_ready && !empty;

	// ==================================================
	// Storage
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
		end
	end

	// ==================================================
	// Pointers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule

// ==== design/adcsop_top.sv ====
/*
 * Digital sample output port of a 12-bit pipelined converter.
 * Holds the synchronisers of the converter clock and input pins, the
 * mapping of the signed input to a straight-binary code, the overrange
 * detection, a pipeline buffer that delays each sample by one converter
 * clock, the output word register with its strobe, and a sticky monitor
 * of the converter clock high time.
 * Assumes the converter clock and quantised input arrive asynchronously as pins,
 * that the input value is steady around each converter clock rise, and that
 * each converter clock phase lasts at least two system clock cycles.
 * Outputs are registered and cleared by the active-low reset.
 */
// Behaviour
// [RULE_01] Sample input on each converter clock rise
// [RULE_02] Output previous sample on next clock rise
// [RULE_03] Twelve-bit straight binary, bit zero least
// [RULE_04] Overrange flag when input exceeds full scale
// [RULE_05] Flag leaves saturated data code untouched
// [RULE_06] Source keeps clock high at most 300ns
// [RULE_07] Source duty cycle between forty and sixty
// [RULE_08] Capture code and flag as one word
`timescale 1ns/10ps
module adcsop_top #(
	parameter int unsigned FIFO_DEPTH = adcsop_pkg::FIFO_DEPTH
) (
	input  wire logic                                i_clk,
	input  wire logic                                i_nrst,
	input  wire logic                                i_conv_clk,
	input  wire logic signed [adcsop_pkg::VIN_W-1:0] i_vin_lsb,
	output logic [adcsop_pkg::CODE_W-1:0]            o_sample_code,
	output logic                                     o_overrange_flag,
	output logic                                     o_sample_strobe,
	output logic                                     o_clock_high_width_fault
);

	// ==================================================
	// Synchroniser state
	logic                                     rst_meta_reg;
	logic                                     rst_n_reg;
	logic                                     clk_meta_reg;
	logic                                     clk_sync_reg;
	logic                                     clk_prev_reg;
	logic signed [adcsop_pkg::VIN_W-1:0]      vin_meta_reg;
	logic signed [adcsop_pkg::VIN_W-1:0]      vin_sync_reg;
	logic                                     rise;

	// ==================================================
	// Conversion path
	logic signed [adcsop_pkg::VIN_W:0]        offset;
	logic [adcsop_pkg::CODE_W-1:0]            code_next;
	logic                                     flag_next;
	adcsop_pkg::adcsop_word_t                 word_next;
	adcsop_pkg::adcsop_word_t                 fifo_out;
	logic                                     fifo_out_valid;
	logic                                     word_pop;

	// ==================================================
	// Output state
	adcsop_pkg::adcsop_word_t                 out_word_reg;
	logic                                     strobe_reg;

	// ==================================================
	// Clock monitor state
	logic [adcsop_pkg::HIGH_CNT_W-1:0]        high_cnt_reg;
	logic                                     high_room;
	logic                                     high_over;
	logic                                     fault_reg;

	// ==================================================
	// Reset release
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// ==================================================
	// Converter clock synchroniser
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			clk_meta_reg <= 1'b0;
			clk_sync_reg <= 1'b0;
		end else begin
			clk_meta_reg <= i_conv_clk;
			clk_sync_reg <= clk_meta_reg;
		end
	end

	// ==================================================
	// Converter clock edge history
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			clk_prev_reg <= 1'b0;
		end else begin
			clk_prev_reg <= clk_sync_reg;
		end
	end

	// ==================================================
	// Input value synchroniser
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			vin_meta_reg <= adcsop_pkg::VIN_RESET;
			vin_sync_reg <= adcsop_pkg::VIN_RESET;
		end else begin
			vin_meta_reg <= i_vin_lsb;
			vin_sync_reg <= vin_meta_reg;
		end
	end

	// [RULE_01] rising edge detect
	assign rise = clk_sync_reg && !clk_prev_reg;

	// ==================================================
	// Quantiser to output code
	assign offset = $signed({vin_sync_reg[adcsop_pkg::VIN_W-1], vin_sync_reg}) + adcsop_pkg::MID_OFFSET;

	// [RULE_03] straight binary saturate
	always_comb begin
		if (offset < 0) begin
			code_next = adcsop_pkg::CODE_ZERO;
		end else if (offset > adcsop_pkg::CODE_TOP) begin
			code_next = adcsop_pkg::CODE_ONES;
		end else begin
			code_next = offset[adcsop_pkg::CODE_W-1:0];
		end
	end

	// ==================================================
	// Overrange detection
	// [RULE_04] overrange by one LSB
	always_comb begin
		flag_next = (vin_sync_reg >= (adcsop_pkg::FS_TOP + adcsop_pkg::OVR_LSB));
	end

	// [RULE_05] code chosen independently
	always_comb begin
		word_next                = adcsop_pkg::WORD_RESET;
		word_next.sample_code    = code_next;
		word_next.overrange_flag = flag_next;
	end

	// ==================================================
	// Sample pipeline buffer
	adcsop_fifo #(
		.WIDTH (adcsop_pkg::WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst_n     (rst_n_reg),
		.i_in_data   (word_next),
		.i_in_valid  (rise),
		.o_in_ready  (),
		.o_out_data  (fifo_out),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (rise)
	);

	// [RULE_02] release previous sample
	assign word_pop = rise && fifo_out_valid;

	// ==================================================
	// Output word register
	// [RULE_02] one edge latency
	// [RULE_08] code and flag together
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			out_word_reg <= adcsop_pkg::WORD_RESET;
		end else if (word_pop) begin
			out_word_reg <= fifo_out;
		end
	end

	// ==================================================
	// Word strobe
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			strobe_reg <= 1'b0;
		end else begin
			strobe_reg <= word_pop;
		end
	end

	// ==================================================
	// Clock high width limits
	// [RULE_06] compare against limit
	assign high_room = (high_cnt_reg <= adcsop_pkg::HIGH_CNT_W'(adcsop_pkg::CLOCK_HIGH_MAX_CYC));
	assign high_over = (high_cnt_reg >= adcsop_pkg::HIGH_CNT_W'(adcsop_pkg::CLOCK_HIGH_MAX_CYC));

	// ==================================================
	// Clock high width counter
	// [RULE_06] high time count
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			high_cnt_reg <= adcsop_pkg::HIGH_CNT_RESET;
		end else if (!clk_sync_reg) begin
			high_cnt_reg <= adcsop_pkg::HIGH_CNT_RESET;
		end else if (high_room) begin
			high_cnt_reg <= high_cnt_reg + 1'b1;
		end
	end

	// ==================================================
	// Sticky high width fault
	// [RULE_06] fault set
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			fault_reg <= 1'b0;
		end else if (clk_sync_reg && high_over) begin
			fault_reg <= 1'b1;
		end
	end

	// ==================================================
	// Outputs
	assign o_sample_code            = out_word_reg.sample_code;
	assign o_overrange_flag         = out_word_reg.overrange_flag;
	assign o_sample_strobe          = strobe_reg;
	assign o_clock_high_width_fault = fault_reg;

endmodule

// ==== verification/adcsop_properties.sv ====
/* Checker bound to adcsop_top.
   Assumes conv clock phases of four cycles or more. */
`timescale 1ns/10ps
module adcsop_properties (
	input wire logic               i_clk,
	input wire logic               i_nrst,
	input wire logic               i_conv_clk,
	input wire logic signed [13:0] i_vin_lsb,
	input wire logic [11:0]        o_sample_code,
	input wire logic               o_overrange_flag,
	input wire logic               o_sample_strobe,
	input wire logic               o_clock_high_width_fault
);
	logic q_reg, arm_reg;
	logic signed [13:0] cur_reg, prv_reg;
	logic [7:0] age_reg, hi_reg;
	wire rise = i_conv_clk & ~q_reg;
	function automatic logic [11:0] code_of(input logic signed [13:0] v);
		return v > 14'sh07FE ? 12'hFFF : v < -14'sh0800 ? 12'h000 : 12'(v + 14'sh0800);
	endfunction
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			{q_reg, arm_reg, cur_reg, prv_reg, age_reg, hi_reg} <= {30'h0, 8'hFF, 8'h00};
		end else begin
			q_reg <= i_conv_clk;
			hi_reg <= i_conv_clk ? hi_reg + 8'(hi_reg != 8'hFF) : 8'h00;
			age_reg <= rise ? 8'h00 : age_reg + 8'(age_reg != 8'hFF);
			if (rise) begin
				{arm_reg, cur_reg, prv_reg} <= {1'b1, i_vin_lsb, cur_reg};
			end
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_rise; rise && arm_reg; endsequence
	sequence s_word; ##[1:5] o_sample_strobe; endsequence
	a_strobe_after_rise:
	assert property (s_rise |-> s_word) else $error("no word after rise");
	a_strobe_needs_rise:
	assert property (o_sample_strobe |-> age_reg <= 8'h05) else $error("word without rise");
	a_word_holds_still:
	assert property (!o_sample_strobe |-> $stable({o_overrange_flag, o_sample_code})) else $error("word moved");
	a_code_matches:
	assert property (o_sample_strobe |-> o_sample_code == code_of(prv_reg)) else $error("code wrong");
	a_flag_matches:
	assert property (o_sample_strobe |-> o_overrange_flag == (prv_reg > 14'sh07FF)) else $error("flag wrong");
	a_flag_saturated:
	assert property (o_overrange_flag |-> o_sample_code == 12'hFFF) else $error("flag without ones");
	a_fault_on_time:
	assert property (hi_reg == 8'h55 |-> o_clock_high_width_fault) else $error("fault late");
	a_fault_needs_high:
	assert property ($rose(o_clock_high_width_fault) |-> hi_reg >= 8'h4B) else $error("fault early");
endmodule
bind adcsop_top adcsop_properties adcsop_properties_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_conv_clk(i_conv_clk),
	.i_vin_lsb(i_vin_lsb), .o_sample_code(o_sample_code), .o_overrange_flag(o_overrange_flag),
	.o_sample_strobe(o_sample_strobe), .o_clock_high_width_fault(o_clock_high_width_fault));

// ==== verification/adcsop_partner.sv ====
/* Clock source and capture model.
   Assumes i_clk also clocks the design. */
`timescale 1ns/10ps
module adcsop_partner (
	input  wire logic                     i_clk,
	input  wire logic                     i_strobe,
	input  wire adcsop_pkg::adcsop_word_t i_word,
	output logic                          o_conv_clk,
	output logic signed [13:0]            o_vin_lsb,
	output adcsop_pkg::adcsop_word_t      o_cap_word,
	output logic                          o_cap_valid
);
	initial begin
		o_conv_clk = 1'b0;
		o_vin_lsb = 14'sh0000;
	end
	task automatic send(input logic signed [13:0] v, input int hi);
		@(posedge i_clk) #1 o_vin_lsb = v;
		repeat (hi) @(posedge i_clk);
		#1 o_conv_clk = 1'b1;
		repeat (hi) @(posedge i_clk);
		#1 o_conv_clk = 1'b0;
	endtask
	always @(posedge i_clk) begin
		o_cap_valid <= i_strobe;
		if (i_strobe) o_cap_word <= i_word;
	end
endmodule

// ==== verification/adc_sample_output_port_tb_top.sv ====
/* Self-checking bench of adcsop_top.
   Assumes adcsop_partner as clock source and capture. */
`timescale 1ns/10ps
module adc_sample_output_port_tb_top;
	logic clk, nrst, conv_clk, ovr, strobe, fault, cap_valid;
	logic signed [13:0] vin;
	logic [11:0] code;
	logic [12:0] cap_word;
	logic [12:0] exp_q[$];
	logic [31:0] r;
	int n_mismatch = 0;
	int n_compared = 0;
	int seed = 32'h575A3458;
	logic signed [13:0] bnd[11] = '{14'sh2000, 14'sh37FF, 14'sh3800, 14'sh3801, 14'sh3FFF, 14'sh0000, 14'sh07FE,
		14'sh07FF, 14'sh0800, 14'sh0801, 14'sh1FFF};
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	adcsop_top adcsop_top_inst (.i_clk(clk), .i_nrst(nrst), .i_conv_clk(conv_clk), .i_vin_lsb(vin),
		.o_sample_code(code), .o_overrange_flag(ovr), .o_sample_strobe(strobe), .o_clock_high_width_fault(fault));
	adcsop_partner adcsop_partner_inst (.i_clk(clk), .i_strobe(strobe), .i_word({ovr, code}),
		.o_conv_clk(conv_clk), .o_vin_lsb(vin), .o_cap_word(cap_word), .o_cap_valid(cap_valid));
	task automatic check(input string what, input logic [12:0] e, input logic [12:0] s);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic drive(input logic signed [13:0] v, input int hi, input bit note);
		if (note) exp_q.push_back({v > 14'sh07FF, v > 14'sh07FE ? 12'hFFF : v < -14'sh0800 ? 12'h000 : 12'(v + 14'sh0800)});
		adcsop_partner_inst.send(v, hi);
	endtask
	always @(posedge clk) begin
		if (cap_valid === 1'b1) begin
			check("word_due", 13'h0001, 13'(exp_q.size() != 0));
			if (exp_q.size() != 0) check("sample_word", exp_q.pop_front(), cap_word);
		end
	end
	initial begin
		nrst = 1'b0;
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clk);
		foreach (bnd[i]) drive(bnd[i], 4, 1'b1);
		$display("test boundary done");
		repeat (200) begin
			r = $random(seed);
			drive(r[13:0], 4 + r[16:14], 1'b1);
		end
		$display("test random done");
		check("fault_early", 13'h0000, 13'(fault));
		drive(14'sh0123, 90, 1'b1);
		drive(14'sh0000, 4, 1'b0);
		repeat (10) @(posedge clk);
		check("fault_late", 13'h0001, 13'(fault));
		check("words_left", 13'h0000, 13'(exp_q.size()));
		$display("test fault done");
		complete_run();
	end
	initial begin
		#100000;
		n_mismatch++;
		complete_run();
	end
endmodule
